/* bfp_pkg.sv */
// Package of shared constants and types for the bridge fault protection block.
package bfp_pkg;

  // Number of power outputs watched (two half-bridges, A and B).
  localparam int unsigned BFP_NUM_OUTPUTS = 2;

  // Filter length on the raw protection comparators, in nanoseconds and cycles.
  localparam int unsigned BFP_CLK_PERIOD_NS = 5;
  localparam int unsigned BFP_TRIG_FILTER_NS = 20;
  localparam int unsigned BFP_TRIG_FILTER_CYC =
    (BFP_TRIG_FILTER_NS + BFP_CLK_PERIOD_NS - 1) / BFP_CLK_PERIOD_NS;
  localparam int unsigned BFP_FILT_W = 3;

  // Reset values.
  localparam logic [BFP_FILT_W-1:0] BFP_FILT_RESET = 3'h0;
  localparam logic [1:0] BFP_BRIDGE_RESET = 2'h0;

  // Half-bridge drive codes: high-side on, low-side on, or high impedance.
  localparam logic [1:0] BFP_DRV_HIZ = 2'h0;
  localparam logic [1:0] BFP_DRV_LOW = 2'h1;
  localparam logic [1:0] BFP_DRV_HIGH = 2'h2;

  // Overcurrent protection states.
  typedef enum logic [2:0] {
    BFP_OC_IDLE      = 3'h1,
    BFP_OC_DISCHARGE = 3'h2,
    BFP_OC_RECHARGE  = 3'h4
  } bfp_oc_state_type;

endpackage : bfp_pkg

/* bfp_trig_filter.sv */
// Small filter that qualifies one raw protection comparator over several cycles.
`timescale 1ns/1ps
module bfp_trig_filter
  import bfp_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic raw,
  output logic      hit
);

  logic [BFP_FILT_W-1:0] cnt_q;

  // Counts consecutive high samples so a switching spike cannot trip the bridge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= BFP_FILT_RESET;
    end else if (!raw) begin
      cnt_q <= BFP_FILT_RESET;
    end else if (cnt_q != BFP_FILT_W'(BFP_TRIG_FILTER_CYC)) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // Registered hit output; it is one cycle later than the count reaching its mark.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hit <= 1'b0;
    end else begin
      hit <= raw && (cnt_q == BFP_FILT_W'(BFP_TRIG_FILTER_CYC));
    end
  end

endmodule : bfp_trig_filter

/* bfp_fault_ctrl.sv */
// Fault protection control for one full-bridge motor driver.
`timescale 1ns/1ps
module bfp_fault_ctrl
  import bfp_pkg::*;
(
  input  wire logic       CORE_CLK,
  input  wire logic       RESETN,
  input  wire logic       STANDBY_INPUT_N,
  input  wire logic       ENABLE_PIN_HIGH,
  input  wire logic       ENABLE_PIN_BELOW_RELEASE,
  input  wire logic [1:0] OVERLOAD_RAW,
  input  wire logic [1:0] SHORT_GND_RAW,
  input  wire logic [1:0] SHORT_SUPPLY_RAW,
  input  wire logic       SHORT_OUTPUTS_RAW,
  input  wire logic       THERMAL_TRIP_TEMP,
  input  wire logic       THERMAL_HYSTERESIS,
  input  wire logic       DIRECTION_INPUT,
  input  wire logic       PWM_INPUT,
  output logic            FAULT_PULL_OUT,
  output logic            FAULT_PULL_OE_N,
  output logic [1:0]      BRIDGE_OUT1,
  output logic [1:0]      BRIDGE_OUT2,
  output logic            BRIDGE_ENABLED,
  output logic            OVERCURRENT_ACTIVE,
  output logic            THERMAL_ACTIVE
);

  localparam int unsigned NTRIG = 3 * BFP_NUM_OUTPUTS + 1;

  // How the pieces fit together, for whoever touches this next.
  //
  // There are two independent fault sources: the filtered output detectors and the thermal flags.
  // Each one has its own record of whether it still holds the bridge off.
  // The overcurrent record is a three-state sequence. The thermal record is a single latch.
  // The single open-drain pull-down is the OR of both records.
  // A release therefore needs every source to agree that it is done.
  //
  // Overcurrent timeline, in clock edges after a detector rises:
  //   four edges of filtering, one edge for the hit register,
  //   and then one edge for the registered pull-down and bridge outputs.
  // The six-edge latency is the price of ignoring switching spikes on the comparators.
  // A shorter filter would react sooner, but it would trip on every hard commutation.
  //
  // Once the pull-down is on, the sequence waits for the pin to fall below the release level.
  // It then lets go, and the outside resistor recharges the capacitor.
  // The bridge stays off until the pin climbs back above the logic-high threshold.
  // Nothing in here counts the off time.
  // It is set entirely by the external network, so a slow network gives a long off time.
  // If the pin never rises, for example because the host keeps holding it low,
  // the sequence stays in recharge and the bridge stays off. That is deliberate.
  //
  // The thermal latch sets at the trip flag and clears on the hysteresis flag or in standby.
  // If both flags are high together, the trip flag wins, so a noisy boundary cannot release the bridge.
  //
  // Standby wins over everything else.
  // It returns the sequence to idle, clears the latch and releases the pin on the next edge.
  // This matches the control circuitry losing its supply.
  // When standby is released, the block starts with no memory of an earlier fault.

  // True while the overcurrent sequence has let go of the bridge.
  // Several outputs decode this, so it lives in one place.
  function automatic logic oc_is_idle(input bfp_oc_state_type st);
    oc_is_idle = (st == BFP_OC_IDLE);
  endfunction : oc_is_idle

  // True while the overcurrent sequence wants the pin pulled down.
  function automatic logic oc_wants_pull(input bfp_oc_state_type st);
    oc_wants_pull = (st == BFP_OC_DISCHARGE);
  endfunction : oc_wants_pull

  logic [NTRIG-1:0] raw_trig;
  logic [NTRIG-1:0] trig_hit;
  logic             oc_trigger;
  logic             active;
  bfp_oc_state_type oc_state_q;
  bfp_oc_state_type oc_state_d;
  logic             therm_q;
  logic             pull_d;
  logic             bridge_on_d;
  logic [1:0]       out1_d;
  logic [1:0]       out2_d;

  // Control circuitry is only alive while standby is released.
  assign active = STANDBY_INPUT_N;

  // Gather every output's overload and short detectors into one trigger vector.
  assign raw_trig = {SHORT_OUTPUTS_RAW, SHORT_SUPPLY_RAW, SHORT_GND_RAW, OVERLOAD_RAW};

  // One filter per detector, so each comparator gets its own deglitch.
  for (genvar g = 0; g < NTRIG; g++) begin : g_filt
    bfp_trig_filter u_filt (
      .clk   (CORE_CLK),
      .rst_n (RESETN),
      .raw   (raw_trig[g] && active),
      .hit   (trig_hit[g])
    );
  end

  assign oc_trigger = |trig_hit;

  // Overcurrent sequence: discharge the pin, then hand recharge to the outside RC.
  always_comb begin
    oc_state_d = oc_state_q;
    unique case (oc_state_q)
      BFP_OC_IDLE: begin
        if (oc_trigger) begin
          oc_state_d = BFP_OC_DISCHARGE;
        end
      end
      BFP_OC_DISCHARGE: begin
        if (ENABLE_PIN_BELOW_RELEASE) begin
          oc_state_d = BFP_OC_RECHARGE;
        end
      end
      BFP_OC_RECHARGE: begin
        // The off time ends only when the host sees the pin above logic high again.
        if (ENABLE_PIN_HIGH) begin
          oc_state_d = BFP_OC_IDLE;
        end
      end
      default: oc_state_d = BFP_OC_DISCHARGE;
    endcase
    if (!active) begin
      oc_state_d = BFP_OC_IDLE;
    end
  end

  // Overcurrent state register.
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      oc_state_q <= BFP_OC_IDLE;
    end else begin
      oc_state_q <= oc_state_d;
    end
  end

  // Thermal latch: sets at the trip point, clears below the hysteresis point or in standby.
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      therm_q <= 1'b0;
    end else if (!active) begin
      therm_q <= 1'b0;
    end else if (THERMAL_TRIP_TEMP) begin
      therm_q <= 1'b1;
    end else if (THERMAL_HYSTERESIS) begin
      therm_q <= 1'b0;
    end
  end

  // Pull-down is the OR of the pending fault requests; a new trigger wins at once.
  assign pull_d = active && (oc_wants_pull(oc_state_d) || therm_q ||
                  (THERMAL_TRIP_TEMP && !therm_q));

  // The bridge runs only with the pin high and no fault still holding it off.
  assign bridge_on_d = active && ENABLE_PIN_HIGH && !pull_d &&
                       oc_is_idle(oc_state_d);

  // Bridge truth table: PWM high drives per direction, PWM low brakes on both low sides.
  always_comb begin
    out1_d = BFP_DRV_HIZ;
    out2_d = BFP_DRV_HIZ;
    if (bridge_on_d) begin
      if (PWM_INPUT && DIRECTION_INPUT) begin
        out1_d = BFP_DRV_HIGH;
        out2_d = BFP_DRV_LOW;
      end else if (PWM_INPUT) begin
        out1_d = BFP_DRV_LOW;
        out2_d = BFP_DRV_HIGH;
      end else begin
        out1_d = BFP_DRV_LOW;
        out2_d = BFP_DRV_LOW;
      end
    end
  end

  // Registered pin and bridge outputs; the open-drain only ever drives zero.
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      FAULT_PULL_OUT  <= 1'b0;
      FAULT_PULL_OE_N <= 1'b1;
      BRIDGE_OUT1     <= BFP_BRIDGE_RESET;
      BRIDGE_OUT2     <= BFP_BRIDGE_RESET;
      BRIDGE_ENABLED  <= 1'b0;
    end else begin
      FAULT_PULL_OUT  <= 1'b0;
      FAULT_PULL_OE_N <= !pull_d;
      BRIDGE_OUT1     <= out1_d;
      BRIDGE_OUT2     <= out2_d;
      BRIDGE_ENABLED  <= bridge_on_d;
    end
  end

  // Status flags mirror the state for observation.
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      OVERCURRENT_ACTIVE <= 1'b0;
      THERMAL_ACTIVE     <= 1'b0;
    end else begin
      OVERCURRENT_ACTIVE <= !oc_is_idle(oc_state_d);
      THERMAL_ACTIVE     <= active && (therm_q || THERMAL_TRIP_TEMP);
    end
  end

endmodule : bfp_fault_ctrl

/* bfp_fault_ctrl_assertions.sv */
// Port-level checks of the bridge fault protection block.
`timescale 1ns/1ps
module bfp_fault_ctrl_assertions (
  input wire logic       CORE_CLK,
  input wire logic       RESETN,
  input wire logic       STANDBY_INPUT_N,
  input wire logic       ENABLE_PIN_HIGH,
  input wire logic       ENABLE_PIN_BELOW_RELEASE,
  input wire logic [1:0] OVERLOAD_RAW,
  input wire logic       THERMAL_TRIP_TEMP,
  input wire logic       THERMAL_HYSTERESIS,
  input wire logic       FAULT_PULL_OUT,
  input wire logic       FAULT_PULL_OE_N,
  input wire logic [1:0] BRIDGE_OUT1,
  input wire logic [1:0] BRIDGE_OUT2,
  input wire logic       OVERCURRENT_ACTIVE,
  input wire logic       THERMAL_ACTIVE
);
  // One clock domain, so clocking and reset are stated once.
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);
  pin_low_hiz_a: assert property (!ENABLE_PIN_HIGH |=> {BRIDGE_OUT1, BRIDGE_OUT2} == 4'h0)
    else $error("bridge driven while pin low");
  standby_off_a: assert property (!STANDBY_INPUT_N |=> {BRIDGE_OUT1, BRIDGE_OUT2, OVERCURRENT_ACTIVE, THERMAL_ACTIVE,
    FAULT_PULL_OE_N} == 7'h01) else $error("standby left state");
  pull_has_cause_a: assert property (!FAULT_PULL_OE_N |-> !FAULT_PULL_OUT && (OVERCURRENT_ACTIVE || THERMAL_ACTIVE))
    else $error("pull-down without fault");
  thermal_trip_a: assert property (THERMAL_TRIP_TEMP && STANDBY_INPUT_N |=> !FAULT_PULL_OE_N && THERMAL_ACTIVE)
    else $error("no thermal pull-down");
  thermal_hold_a: assert property (THERMAL_ACTIVE && !THERMAL_HYSTERESIS && STANDBY_INPUT_N |=> THERMAL_ACTIVE
    && !FAULT_PULL_OE_N) else $error("thermal released early");
  overload_seen_a: assert property ((OVERLOAD_RAW[0] && STANDBY_INPUT_N)[*4] |-> ##[1:3] OVERCURRENT_ACTIVE)
    else $error("overload missed");
  oc_hold_a: assert property (OVERCURRENT_ACTIVE && !FAULT_PULL_OE_N && !ENABLE_PIN_BELOW_RELEASE && STANDBY_INPUT_N
    |=> !FAULT_PULL_OE_N) else $error("pull-down dropped early");
  oc_release_a: assert property (OVERCURRENT_ACTIVE && ENABLE_PIN_BELOW_RELEASE && !THERMAL_ACTIVE
    && !THERMAL_TRIP_TEMP && STANDBY_INPUT_N |=> FAULT_PULL_OE_N) else $error("pull-down kept");
endmodule : bfp_fault_ctrl_assertions
bind bfp_fault_ctrl bfp_fault_ctrl_assertions i_chk (.*);

/* bfp_host_model.sv */
// Host side of the enable/fault pin: RC network plus a host pull-low.
`timescale 1ns/1ps
module bfp_host_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic oe_n,
  input  wire logic hold_low,
  output logic      pin_high,
  output logic      below_rel
);
  logic [5:0] lvl_q;
  // Pin voltage as a count; recharge is slow, so the off time is set by the network.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) lvl_q <= 6'h3f;
    else if (!oe_n || hold_low) lvl_q <= (lvl_q > 6'h03) ? lvl_q - 6'h04 : 6'h00;
    else if (lvl_q != 6'h3f) lvl_q <= lvl_q + 6'h01;
  end
  // Logic-high threshold near the top, release threshold near ground.
  assign pin_high  = lvl_q > 6'h2f;
  assign below_rel = lvl_q < 6'h04;
endmodule : bfp_host_model

/* bridge_fault_protection_tb_top.sv */
// Self-checking bench for the bridge fault protection control.
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; $display("wrong value %s exp %h got %h", n, e, g); end end
module bridge_fault_protection_tb_top
  import bfp_pkg::*;
;
  logic CORE_CLK = 1'b0, RESETN = 1'b0, STANDBY_INPUT_N = 1'b1, THERMAL_TRIP_TEMP = 1'b0, THERMAL_HYSTERESIS = 1'b1;
  logic DIRECTION_INPUT = 1'b0, PWM_INPUT = 1'b0, hold = 1'b0, ENABLE_PIN_HIGH, ENABLE_PIN_BELOW_RELEASE;
  logic FAULT_PULL_OUT, FAULT_PULL_OE_N, BRIDGE_ENABLED, OVERCURRENT_ACTIVE, THERMAL_ACTIVE, SHORT_OUTPUTS_RAW;
  logic [1:0] BRIDGE_OUT1, BRIDGE_OUT2, OVERLOAD_RAW, SHORT_GND_RAW, SHORT_SUPPLY_RAW;
  logic [6:0] det = 7'h00;
  logic [4:0] exp_q[$];
  logic [4:0] res, last = 5'h10, ln = 5'h10, e;
  int miscompares = 0, total_checks = 0, cyc = 0, seed = 32'hc345;
  assign {SHORT_OUTPUTS_RAW, SHORT_SUPPLY_RAW, SHORT_GND_RAW, OVERLOAD_RAW} = det;
  bfp_fault_ctrl i_dut (.*);
  bfp_host_model i_host (.clk(CORE_CLK), .rst_n(RESETN), .oe_n(FAULT_PULL_OE_N), .hold_low(hold),
    .pin_high(ENABLE_PIN_HIGH), .below_rel(ENABLE_PIN_BELOW_RELEASE));
  // Clock and a cycle ceiling well above the expected run of about 800 cycles.
  always #2.5 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 5000) begin miscompares++; tally_and_finish(); end
  end
  // Each change of pull-down or bridge drive is a result, matched to the oldest note.
  always @(posedge CORE_CLK) begin
    #1;
    res = {FAULT_PULL_OE_N, BRIDGE_OUT1, BRIDGE_OUT2};
    if (RESETN && res !== last) begin
      e = exp_q.size() ? exp_q.pop_front() : 5'h1f;
      `CHK("pin and bridge", e, res)
    end
    if (RESETN) begin
      `CHK("pull data", 1'b0, FAULT_PULL_OUT)
      `CHK("bridge enabled", (res[3:0] != 4'h0), BRIDGE_ENABLED)
    end
    last = res;
  end
  function automatic logic [4:0] drv(input logic d, input logic p);
    drv = {1'b1, (d & p) ? BFP_DRV_HIGH : BFP_DRV_LOW, (!d & p) ? BFP_DRV_HIGH : BFP_DRV_LOW};
  endfunction : drv
  task automatic step(input int n);
    repeat (n) @(posedge CORE_CLK);
    #1;
  endtask : step
  // Only a change of expected state is a result, so repeats are not noted.
  task automatic note(input logic [4:0] v);
    if (v !== ln) exp_q.push_back(v);
    ln = v;
  endtask : note
  task automatic settle;
    int n;
    n = 0;
    while ((OVERCURRENT_ACTIVE || THERMAL_ACTIVE || !ENABLE_PIN_HIGH) && n < 400) begin step(1); n++; end
    step(3);
  endtask : settle
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  initial begin
    step(4);
    RESETN = 1'b1;
    note(drv(1'b0, 1'b0));
    step(3);
    // Random direction and duty inputs walk the drive table.
    repeat (24) begin
      {DIRECTION_INPUT, PWM_INPUT} = 2'($random(seed));
      note(drv(DIRECTION_INPUT, PWM_INPUT));
      step(2);
    end
    // Every detector in turn, then over-temperature held past the pin release.
    for (int k = 0; k < 8; k++) begin
      note(5'h00);
      note(5'h10);
      note(drv(DIRECTION_INPUT, PWM_INPUT));
      if (k < 7) det[k] = 1'b1;
      else {THERMAL_TRIP_TEMP, THERMAL_HYSTERESIS} = 2'h2;
      step(6);
      {det, THERMAL_TRIP_TEMP} = 8'h00;
      step(40);
      THERMAL_HYSTERESIS = 1'b1;
      settle();
    end
    // Host pull-low, then standby, each with the bridge driving.
    {DIRECTION_INPUT, PWM_INPUT} = 2'h3;
    note(drv(1'b1, 1'b1));
    step(3);
    for (int k = 0; k < 2; k++) begin
      note(5'h10);
      {hold, STANDBY_INPUT_N} = (k == 0) ? 2'h3 : 2'h0;
      step(30);
      note(drv(1'b1, 1'b1));
      {hold, STANDBY_INPUT_N} = 2'h1;
      settle();
    end
    `CHK("notes left", 0, exp_q.size())
    tally_and_finish();
  end
endmodule : bridge_fault_protection_tb_top
